/* tmg_gateway.sv */
/*
  Thread message gateway: channel open/close, forwarding, time reads and barriers.
  Assumes requests, writeback and notification handshakes come from logic on clk.
*/
module tmg_gateway
  import tmg_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [TMG_DESC_W-1:0] req_desc,
  input wire logic [TMG_DATA_W-1:0] req_payload,
  input wire logic [TMG_THREAD_W-1:0] req_sender,
  input wire logic [TMG_REG_W-1:0] req_post_reg,
  output logic wb_valid,
  input wire logic wb_ready,
  output logic [TMG_THREAD_W-1:0] wb_thread,
  output logic [TMG_REG_W-1:0] wb_reg,
  output logic [TMG_DATA_W-1:0] wb_data,
  output logic [TMG_BE_W-1:0] wb_byte_en,
  output logic ntf_valid,
  input wire logic ntf_ready,
  output logic [TMG_THREAD_W-1:0] ntf_thread,
  output logic ntf_secondary,
  input wire logic [63:0] wall_time,
  input wire logic ctx_run,
  input wire logic ctx_restore,
  input wire logic [63:0] ctx_restore_time,
  output logic [63:0] ctx_time,
  input wire logic bar_cfg_valid,
  input wire logic [TMG_BAR_ID_W-1:0] bar_cfg_id,
  input wire logic [TMG_BAR_CNT_W-1:0] bar_cfg_count,
  output logic init_done
);
  tmg_state_t state, next_state, resume, next_resume;
  logic [TMG_DESC_W-1:0] desc, next_desc;
  logic [TMG_DATA_W-1:0] pl, next_pl;
  logic [TMG_THREAD_W-1:0] sender, next_sender;
  logic [TMG_REG_W-1:0] post, next_post;
  logic [2:0] err, next_err;
  logic [TMG_THREAD_W-1:0] scrub, next_scrub;
  logic next_init_done;
  logic next_wb_valid;
  logic [TMG_THREAD_W-1:0] next_wb_thread;
  logic [TMG_REG_W-1:0] next_wb_reg;
  logic [TMG_DATA_W-1:0] next_wb_data;
  logic [TMG_BE_W-1:0] next_wb_byte_en;
  logic next_ntf_valid;
  logic [TMG_THREAD_W-1:0] next_ntf_thread;
  logic next_ntf_secondary;
  logic [TMG_BAR_CNT_W-1:0] bar_cnt [TMG_BAR_N];
  logic [TMG_BAR_CNT_W-1:0] bar_term [TMG_BAR_N];
  logic [TMG_BAR_CNT_W-1:0] next_bar_cnt [TMG_BAR_N];
  logic [TMG_BAR_CNT_W-1:0] next_bar_term [TMG_BAR_N];
  logic [TMG_BAR_ID_W-1:0] rel_id, next_rel_id;
  logic [TMG_BAR_CNT_W-1:0] rel_idx, next_rel_idx;
  logic [TMG_BAR_CNT_W-1:0] rel_last, next_rel_last;
  logic [63:0] next_ctx_time;

  logic f_valid;
  logic f_pop;
  logic [TMG_REQ_W-1:0] f_data;
  logic chan_we;
  logic [TMG_THREAD_W-1:0] chan_waddr;
  logic [TMG_CHAN_W-1:0] chan_wdata;
  logic [TMG_CHAN_W-1:0] chan_rdata;
  logic memb_we;
  logic [TMG_MEMB_AW-1:0] memb_waddr;
  logic [TMG_THREAD_W-1:0] memb_rdata;

  logic [2:0] opcode;
  logic ack_req;
  logic [1:0] notify;
  logic [31:0] dw2;
  logic [31:0] dw4;
  logic [31:0] dw5;
  logic [TMG_THREAD_W-1:0] rcpt;
  logic [2:0] seg_len;
  logic [4:0] byte_off;
  logic [15:0] seg_be;
  logic [TMG_BAR_ID_W-1:0] bar_id;
  logic [TMG_BAR_CNT_W-1:0] bar_new;
  logic [TMG_BAR_CNT_W-1:0] bar_lim;
  logic [127:0] time_half;
  logic [31:0] ack_dw;

  assign opcode = desc[TMG_D_OP_LO +: 3];
  assign ack_req = desc[TMG_D_ACK];
  assign notify = desc[TMG_D_NTF_LO +: 2];
  assign dw2 = pl[TMG_DW2 +: 32];
  assign dw4 = pl[TMG_DW4 +: 32];
  assign dw5 = pl[TMG_DW5 +: 32];
  // Recipient from slice, sub-slice, unit and thread; key and spawn tag unused
  assign rcpt = {dw4[TMG_F_SLICE_LO +: 3], dw4[TMG_F_SUB_LO +: 2],
                 dw4[TMG_F_EU_LO +: 4], dw4[TMG_F_TID_LO +: 3]};
  assign seg_len = dw5[TMG_F_LEN_LO +: 3];
  assign byte_off = dw5[TMG_F_BOFF_LO +: 5];
  assign bar_id = dw2[TMG_F_BID_LO +: TMG_BAR_ID_W];
  assign bar_lim = dw2[TMG_F_BCEN] ? dw2[TMG_F_BCNT_LO +: TMG_BAR_CNT_W] : bar_term[bar_id];
  assign bar_new = bar_cnt[bar_id] + 1'b1;
  assign ack_dw = {12'h000, TMG_SFID, 13'h0000, err};
  // Time fields: 12 low quarter-ns bits on top of a dword, then the high part
  assign time_half = {ctx_time[TMG_T_LOW_W +: 32],
                      ctx_time[TMG_T_LOW_W-1:0], {TMG_T_PAD_W{1'b0}},
                      wall_time[TMG_T_LOW_W +: 32],
                      wall_time[TMG_T_LOW_W-1:0], {TMG_T_PAD_W{1'b0}}};

  always_comb begin
    case (seg_len)
      TMG_LEN_BYTE: seg_be = 16'h0001;
      TMG_LEN_WORD: seg_be = 16'h0003;
      TMG_LEN_DW: seg_be = 16'h000f;
      TMG_LEN_2DW: seg_be = 16'h00ff;
      TMG_LEN_4DW: seg_be = 16'hffff;
      default: seg_be = 16'h0000;
    endcase
  end

  assign f_pop = (state == TMG_S_IDLE) && f_valid;

  tmg_fifo #(
    .WIDTH(TMG_REQ_W),
    .DEPTH(TMG_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data({req_sender, req_post_reg, req_desc, req_payload}),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  // Per-thread channel entry: open flag and register base
  tmg_ram #(
    .WIDTH(TMG_CHAN_W),
    .DEPTH(TMG_CHAN_DEPTH)
  ) u_chan (
    .clk(clk),
    .wr_en(chan_we),
    .wr_addr(chan_waddr),
    .wr_data(chan_wdata),
    .rd_addr(rcpt),
    .rd_data(chan_rdata)
  );

  // Recorded barrier members, indexed by barrier and arrival slot
  tmg_ram #(
    .WIDTH(TMG_THREAD_W),
    .DEPTH(TMG_MEMB_DEPTH)
  ) u_memb (
    .clk(clk),
    .wr_en(memb_we),
    .wr_addr(memb_waddr),
    .wr_data(sender),
    .rd_addr({rel_id, rel_idx}),
    .rd_data(memb_rdata)
  );

  always_comb begin
    next_state = state;
    next_resume = resume;
    next_desc = desc;
    next_pl = pl;
    next_sender = sender;
    next_post = post;
    next_err = err;
    next_scrub = scrub;
    next_init_done = init_done;
    next_wb_valid = wb_valid;
    next_wb_thread = wb_thread;
    next_wb_reg = wb_reg;
    next_wb_data = wb_data;
    next_wb_byte_en = wb_byte_en;
    next_ntf_valid = ntf_valid;
    next_ntf_thread = ntf_thread;
    next_ntf_secondary = ntf_secondary;
    next_bar_cnt = bar_cnt;
    next_bar_term = bar_term;
    next_rel_id = rel_id;
    next_rel_idx = rel_idx;
    next_rel_last = rel_last;
    chan_we = 1'b0;
    chan_waddr = sender;
    chan_wdata = '0;
    memb_we = 1'b0;
    memb_waddr = {bar_id, bar_cnt[bar_id]};
    if (bar_cfg_valid) begin
      next_bar_term[bar_cfg_id] = bar_cfg_count;
    end
    case (state)
      TMG_S_INIT: begin
        // Close every channel after reset
        chan_we = 1'b1;
        chan_waddr = scrub;
        next_scrub = scrub + 1'b1;
        if (scrub == '1) begin
          next_init_done = 1'b1;
          next_state = TMG_S_IDLE;
        end
      end
      TMG_S_IDLE: begin
        if (f_valid) begin
          {next_sender, next_post, next_desc, next_pl} = f_data;
          next_state = TMG_S_DEC;
        end
      end
      TMG_S_DEC: begin
        next_err = TMG_ERR_OK;
        next_state = ack_req ? TMG_S_ACK : TMG_S_IDLE;
        case (opcode)
          TMG_OP_OPEN: begin
            chan_we = 1'b1;
            chan_wdata = {1'b1, dw5[TMG_F_ROFF_LO +: TMG_REG_W]};
          end
          TMG_OP_CLOSE: begin
            chan_we = 1'b1;
          end
          TMG_OP_FWD: begin
            if (seg_len > TMG_LEN_4DW) begin
              next_err = TMG_ERR_SIZE;
            end else begin
              next_state = TMG_S_LOOK;
            end
          end
          TMG_OP_TIME: begin
            if (ack_req) begin
              next_wb_valid = 1'b1;
              next_wb_thread = sender;
              next_wb_reg = post;
              // Half select keeps the other half untouched
              next_wb_data = dw5[TMG_F_HALF] ? {time_half, 128'h0} : {128'h0, time_half};
              next_wb_byte_en = dw5[TMG_F_HALF] ? TMG_BE_HIGH : TMG_BE_LOW;
              next_resume = TMG_S_IDLE;
              next_state = TMG_S_WR;
            end
          end
          TMG_OP_BAR: begin
            memb_we = 1'b1;
            next_bar_term[bar_id] = bar_lim;
            next_state = TMG_S_IDLE;
            if (bar_new == bar_lim) begin
              next_rel_id = bar_id;
              next_rel_idx = '0;
              next_rel_last = bar_lim - 1'b1;
              next_bar_cnt[bar_id] = bar_new;
              next_state = TMG_S_REL_RD;
            end else begin
              next_bar_cnt[bar_id] = bar_new;
            end
          end
          TMG_OP_BUPD: begin
            next_state = TMG_S_IDLE;
          end
          default: begin
            next_err = TMG_ERR_OPCODE;
          end
        endcase
      end
      TMG_S_LOOK: begin
        if (!chan_rdata[TMG_CHAN_W-1]) begin
          next_err = TMG_ERR_CLOSED;
          next_state = ack_req ? TMG_S_ACK : TMG_S_IDLE;
        end else begin
          next_wb_valid = 1'b1;
          next_wb_thread = rcpt;
          next_wb_reg = chan_rdata[TMG_REG_W-1:0] + dw5[TMG_F_ROFF_LO +: TMG_REG_W];
          next_wb_data = TMG_DATA_W'({128'h0, pl[127:0]} << {byte_off, 3'h0});
          next_wb_byte_en = TMG_BE_W'({16'h0000, seg_be} << byte_off);
          next_state = TMG_S_WR;
          if (notify != TMG_NTF_NONE) begin
            next_resume = TMG_S_NTF;
          end else begin
            next_resume = ack_req ? TMG_S_ACK : TMG_S_IDLE;
          end
        end
      end
      TMG_S_WR: begin
        if (wb_ready) begin
          next_wb_valid = 1'b0;
          next_state = resume;
          if (resume == TMG_S_NTF) begin
            next_ntf_valid = 1'b1;
            next_ntf_thread = rcpt;
            next_ntf_secondary = (notify == TMG_NTF_SECOND);
          end
        end
      end
      TMG_S_NTF: begin
        if (ntf_ready) begin
          next_ntf_valid = 1'b0;
          next_state = ack_req ? TMG_S_ACK : TMG_S_IDLE;
        end
      end
      TMG_S_ACK: begin
        next_wb_valid = 1'b1;
        next_wb_thread = sender;
        next_wb_reg = post;
        next_wb_data = {224'h0, ack_dw};
        next_wb_byte_en = TMG_BE_ACK;
        next_resume = TMG_S_IDLE;
        next_state = TMG_S_WR;
      end
      TMG_S_REL_RD: begin
        next_state = TMG_S_REL_LD;
      end
      TMG_S_REL_LD: begin
        next_ntf_valid = 1'b1;
        next_ntf_thread = memb_rdata;
        next_ntf_secondary = 1'b0;
        next_state = TMG_S_REL_NTF;
      end
      TMG_S_REL_NTF: begin
        if (ntf_ready) begin
          next_ntf_valid = 1'b0;
          next_rel_idx = rel_idx + 1'b1;
          next_state = TMG_S_REL_RD;
          if (rel_idx == rel_last) begin
            next_bar_cnt[rel_id] = '0;
            next_state = TMG_S_IDLE;
          end
        end
      end
      default: begin
        next_state = TMG_S_IDLE;
      end
    endcase
  end

  always_comb begin
    if (ctx_restore) begin
      next_ctx_time = ctx_restore_time;
    end else if (ctx_run) begin
      next_ctx_time = ctx_time + TMG_QNS_PER_CLK;
    end else begin
      next_ctx_time = ctx_time;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= TMG_S_INIT;
      resume <= TMG_S_IDLE;
      desc <= '0;
      pl <= '0;
      sender <= '0;
      post <= '0;
      err <= TMG_ERR_OK;
      scrub <= '0;
      init_done <= 1'b0;
      wb_valid <= 1'b0;
      wb_thread <= '0;
      wb_reg <= '0;
      wb_data <= '0;
      wb_byte_en <= '0;
      ntf_valid <= 1'b0;
      ntf_thread <= '0;
      ntf_secondary <= 1'b0;
      bar_cnt <= '{default: '0};
      bar_term <= '{default: '0};
      rel_id <= '0;
      rel_idx <= '0;
      rel_last <= '0;
      ctx_time <= '0;
    end else begin
      state <= next_state;
      resume <= next_resume;
      desc <= next_desc;
      pl <= next_pl;
      sender <= next_sender;
      post <= next_post;
      err <= next_err;
      scrub <= next_scrub;
      init_done <= next_init_done;
      wb_valid <= next_wb_valid;
      wb_thread <= next_wb_thread;
      wb_reg <= next_wb_reg;
      wb_data <= next_wb_data;
      wb_byte_en <= next_wb_byte_en;
      ntf_valid <= next_ntf_valid;
      ntf_thread <= next_ntf_thread;
      ntf_secondary <= next_ntf_secondary;
      bar_cnt <= next_bar_cnt;
      bar_term <= next_bar_term;
      rel_id <= next_rel_id;
      rel_idx <= next_rel_idx;
      rel_last <= next_rel_last;
      ctx_time <= next_ctx_time;
    end
  end
endmodule : tmg_gateway

/* tmg_pkg.sv */
/*
  Shared constants, field positions and state codes for the thread message gateway.
  Assumes a single 250 MHz clock domain and 256-bit request messages.
*/
package tmg_pkg;
  localparam int TMG_THREAD_W = 12;
  localparam int TMG_REG_W = 8;
  localparam int TMG_DATA_W = 256;
  localparam int TMG_BE_W = 32;
  localparam int TMG_DESC_W = 32;
  localparam int TMG_REQ_W = TMG_THREAD_W + TMG_REG_W + TMG_DESC_W + TMG_DATA_W;
  localparam int TMG_FIFO_DEPTH = 32;
  localparam int TMG_CHAN_W = 9;
  localparam int TMG_CHAN_DEPTH = 4096;
  localparam int TMG_BAR_N = 16;
  localparam int TMG_BAR_ID_W = 4;
  localparam int TMG_BAR_CNT_W = 6;
  localparam int TMG_MEMB_AW = TMG_BAR_ID_W + TMG_BAR_CNT_W;
  localparam int TMG_MEMB_DEPTH = 1024;

  // Shared function ID of the gateway; value is arbitrary
  localparam logic [3:0] TMG_SFID = 4'h3;

  // Request type codes
  localparam logic [2:0] TMG_OP_OPEN = 3'h0;
  localparam logic [2:0] TMG_OP_CLOSE = 3'h1;
  localparam logic [2:0] TMG_OP_FWD = 3'h2;
  localparam logic [2:0] TMG_OP_TIME = 3'h3;
  localparam logic [2:0] TMG_OP_BAR = 3'h4;
  localparam logic [2:0] TMG_OP_BUPD = 3'h5;

  // Acknowledgement error codes
  localparam logic [2:0] TMG_ERR_OK = 3'h0;
  localparam logic [2:0] TMG_ERR_CLOSED = 3'h2;
  localparam logic [2:0] TMG_ERR_OPCODE = 3'h5;
  localparam logic [2:0] TMG_ERR_SIZE = 3'h6;

  // Segment length codes
  localparam logic [2:0] TMG_LEN_BYTE = 3'h0;
  localparam logic [2:0] TMG_LEN_WORD = 3'h1;
  localparam logic [2:0] TMG_LEN_DW = 3'h2;
  localparam logic [2:0] TMG_LEN_2DW = 3'h3;
  localparam logic [2:0] TMG_LEN_4DW = 3'h4;

  // Descriptor fields
  localparam int TMG_D_OP_LO = 0;
  localparam int TMG_D_ACK = 14;
  localparam int TMG_D_NTF_LO = 15;
  localparam logic [1:0] TMG_NTF_NONE = 2'h0;
  localparam logic [1:0] TMG_NTF_SECOND = 2'h2;

  // Payload dword base positions and fields within a dword
  localparam int TMG_DW2 = 64;
  localparam int TMG_DW4 = 128;
  localparam int TMG_DW5 = 160;
  localparam int TMG_F_LEN_LO = 8;
  localparam int TMG_F_BOFF_LO = 16;
  localparam int TMG_F_ROFF_LO = 21;
  localparam int TMG_F_SLICE_LO = 26;
  localparam int TMG_F_SUB_LO = 24;
  localparam int TMG_F_EU_LO = 20;
  localparam int TMG_F_TID_LO = 16;
  localparam int TMG_F_HALF = 31;
  localparam int TMG_F_BID_LO = 24;
  localparam int TMG_F_BCEN = 15;
  localparam int TMG_F_BCNT_LO = 9;
  localparam int TMG_F_EC_LO = 0;
  localparam int TMG_F_SF_LO = 16;

  // Time fields: low part is 12 bits of quarter-ns, high part starts at bit 12
  localparam int TMG_T_LOW_W = 12;
  localparam int TMG_T_PAD_W = 20;
  localparam int TMG_CLK_PERIOD_NS = 4;
  localparam int TMG_QNS_PER_NS = 4;
  localparam logic [63:0] TMG_QNS_PER_CLK = 64'(TMG_CLK_PERIOD_NS * TMG_QNS_PER_NS);

  localparam logic [TMG_BE_W-1:0] TMG_BE_ACK = 32'h0000000f;
  localparam logic [TMG_BE_W-1:0] TMG_BE_LOW = 32'h0000ffff;
  localparam logic [TMG_BE_W-1:0] TMG_BE_HIGH = 32'hffff0000;

  typedef enum logic [9:0] {
    TMG_S_INIT = 10'h001,
    TMG_S_IDLE = 10'h002,
    TMG_S_DEC = 10'h004,
    TMG_S_LOOK = 10'h008,
    TMG_S_WR = 10'h010,
    TMG_S_NTF = 10'h020,
    TMG_S_ACK = 10'h040,
    TMG_S_REL_RD = 10'h080,
    TMG_S_REL_LD = 10'h100,
    TMG_S_REL_NTF = 10'h200
  } tmg_state_t;
endpackage : tmg_pkg

/* tmg_fifo.sv */
/*
  Request FIFO with valid/ready on both sides and a registered ready.
  Assumes DEPTH is a power of two and a single clock.
*/
module tmg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic rdy;
  logic [AW-1:0] next_wp;
  logic [AW-1:0] next_rp;
  logic [AW:0] next_cnt;
  logic next_rdy;
  logic push;
  logic pop;

  assign push = in_valid & rdy;
  assign pop = out_valid & out_ready;
  assign in_ready = rdy;
  assign out_valid = (cnt != '0);
  assign out_data = mem[rp];

  always_comb begin
    next_wp = push ? wp + 1'b1 : wp;
    next_rp = pop ? rp + 1'b1 : rp;
    next_cnt = cnt;
    if (push && !pop) begin
      next_cnt = cnt + 1'b1;
    end else if (pop && !push) begin
      next_cnt = cnt - 1'b1;
    end
    next_rdy = (next_cnt != FULL);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
      rdy <= 1'b1;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
      rdy <= next_rdy;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end
endmodule : tmg_fifo

/* tmg_ram.sv */
/*
  Simple dual-port memory with registered read data.
  Assumes the owner initialises contents before relying on them.
*/
module tmg_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : tmg_ram

/* tmg_gateway_properties.sv */
/*
  Port checker for the thread message gateway, bound to its top module.
  Assumes one clock domain and the asynchronous active-low reset nrst.
*/
module tmg_gateway_properties
  import tmg_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_valid,
  input wire logic wb_ready,
  input wire logic [TMG_DATA_W-1:0] wb_data,
  input wire logic [TMG_BE_W-1:0] wb_byte_en,
  input wire logic ntf_valid,
  input wire logic ntf_ready,
  input wire logic [TMG_THREAD_W-1:0] ntf_thread,
  input wire logic ctx_run,
  input wire logic ctx_restore,
  input wire logic [63:0] ctx_restore_time,
  input wire logic [63:0] ctx_time,
  input wire logic init_done
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  property p_wb_hold;
    wb_valid && !wb_ready |=> wb_valid && $stable(wb_data) && $stable(wb_byte_en);
  endproperty
  a_wb_hold: assert property (p_wb_hold) else $error("write request changed while stalled");
  property p_wb_drop;
    wb_valid && wb_ready |=> !wb_valid;
  endproperty
  a_wb_drop: assert property (p_wb_drop) else $error("write request repeated");
  property p_ntf_hold;
    ntf_valid && !ntf_ready |=> ntf_valid && $stable(ntf_thread);
  endproperty
  a_ntf_hold: assert property (p_ntf_hold) else $error("notification changed while stalled");
  property p_ntf_drop;
    ntf_valid && ntf_ready |=> !ntf_valid;
  endproperty
  a_ntf_drop: assert property (p_ntf_drop) else $error("notification repeated");
  property p_ctx_run;
    $past(nrst) && $past(ctx_run) && !$past(ctx_restore) |-> ctx_time == $past(ctx_time) + 64'h10;
  endproperty
  a_ctx_run: assert property (p_ctx_run) else $error("context time step wrong");
  property p_ctx_hold;
    $past(nrst) && !$past(ctx_run) && !$past(ctx_restore) |-> $stable(ctx_time);
  endproperty
  a_ctx_hold: assert property (p_ctx_hold) else $error("context time moved while idle");
  property p_ctx_rest;
    $past(nrst) && $past(ctx_restore) |-> ctx_time == $past(ctx_restore_time);
  endproperty
  a_ctx_rest: assert property (p_ctx_rest) else $error("context time not restored");
  property p_init;
    !init_done |-> !wb_valid && !ntf_valid;
  endproperty
  a_init: assert property (p_init) else $error("output before table scrub");
endmodule : tmg_gateway_properties

bind tmg_gateway tmg_gateway_properties tmg_gateway_properties_i (.clk(clk), .nrst(nrst),
  .wb_valid(wb_valid), .wb_ready(wb_ready), .wb_data(wb_data), .wb_byte_en(wb_byte_en),
  .ntf_valid(ntf_valid), .ntf_ready(ntf_ready), .ntf_thread(ntf_thread), .ctx_run(ctx_run),
  .ctx_restore(ctx_restore), .ctx_restore_time(ctx_restore_time), .ctx_time(ctx_time),
  .init_done(init_done));

/* tmg_thread_model.sv */
/*
  Recipient thread model: takes register writes and notifications.
  Assumes falling-edge stimulus; stall forces full back-pressure.
*/
module tmg_thread_model (
  input wire logic clk,
  input wire logic stall,
  output logic wb_ready,
  output logic ntf_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wb_ready = 1'b0;
    ntf_ready = 1'b0;
  end
  // Answers promptly or slowly at random
  always @(negedge clk) begin
    wb_ready = !stall && ($urandom % 4 != 0);
    ntf_ready = !stall && ($urandom % 3 != 0);
  end
endmodule : tmg_thread_model

/* tb_tmg_gateway.sv */
/*
  Self-checking bench for the thread message gateway.
  Assumes the thread model, the bound checker and a 250 MHz clock.
*/
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
  $display("wrong value at %0t: mismatch", $time); end end
module tb_tmg_gateway
  import tmg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] OPS [7] = '{TMG_OP_FWD, TMG_OP_FWD, TMG_OP_FWD, 3'h6, 3'h7,
    TMG_OP_CLOSE, TMG_OP_FWD};
  localparam logic [2:0] ERRS [7] = '{TMG_ERR_SIZE, TMG_ERR_SIZE, TMG_ERR_SIZE,
    TMG_ERR_OPCODE, TMG_ERR_OPCODE, TMG_ERR_OK, TMG_ERR_CLOSED};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  logic ctx_run = 1'b0;
  logic ctx_restore = 1'b0;
  logic bar_cfg_valid = 1'b0;
  logic stall = 1'b0;
  logic [31:0] req_desc = '0;
  logic [255:0] req_payload = '0;
  logic [11:0] req_sender = '0;
  logic [7:0] req_post_reg = '0;
  logic [63:0] wall_time = '0;
  logic [63:0] ctx_restore_time = '0;
  logic [3:0] bar_cfg_id = '0;
  logic [5:0] bar_cfg_count = '0;
  logic req_ready, wb_valid, wb_ready, ntf_valid, ntf_ready, ntf_secondary, init_done;
  logic [11:0] wb_thread, ntf_thread;
  logic [7:0] wb_reg;
  logic [255:0] wb_data;
  logic [31:0] wb_byte_en;
  logic [63:0] ctx_time;
  logic [307:0] exp_wb[$];
  logic [12:0] exp_ntf[$];
  int failures = 0;
  int num_checks = 0;

  tmg_gateway tmg_gateway_i (.clk(clk), .nrst(nrst), .req_valid(req_valid),
    .req_ready(req_ready), .req_desc(req_desc), .req_payload(req_payload),
    .req_sender(req_sender), .req_post_reg(req_post_reg), .wb_valid(wb_valid),
    .wb_ready(wb_ready), .wb_thread(wb_thread), .wb_reg(wb_reg), .wb_data(wb_data),
    .wb_byte_en(wb_byte_en), .ntf_valid(ntf_valid), .ntf_ready(ntf_ready),
    .ntf_thread(ntf_thread), .ntf_secondary(ntf_secondary), .wall_time(wall_time),
    .ctx_run(ctx_run), .ctx_restore(ctx_restore), .ctx_restore_time(ctx_restore_time),
    .ctx_time(ctx_time), .bar_cfg_valid(bar_cfg_valid), .bar_cfg_id(bar_cfg_id),
    .bar_cfg_count(bar_cfg_count), .init_done(init_done));
  tmg_thread_model tmg_thread_model_i (.clk(clk), .stall(stall), .wb_ready(wb_ready),
    .ntf_ready(ntf_ready));

  always #2 clk = ~clk;

  function automatic logic [255:0] bm(logic [31:0] be);
    for (int i = 0; i < 32; i++) bm[8*i+:8] = {8{be[i]}};
  endfunction : bm
  function automatic logic [31:0] dsc(logic [2:0] op, logic a, logic [1:0] n);
    return {15'h0, n, a, 11'h0, op};
  endfunction : dsc
  function automatic logic [31:0] rcp(logic [11:0] r);
    return {3'h0, r[11:9], r[8:7], r[6:3], 1'b0, r[2:0], 16'($urandom)};
  endfunction : rcp

  // Results are compared in arrival order
  always @(posedge clk) begin
    logic [307:0] e;
    if (wb_valid && wb_ready) begin
      e = exp_wb.size() ? exp_wb.pop_front() : 'x;
      `CHK({wb_thread, wb_reg, wb_byte_en, wb_data & bm(wb_byte_en)}, {e[307:288], e[31:0], e[287:32] & bm(e[31:0])})
    end
    if (ntf_valid && ntf_ready) begin
      e[12:0] = exp_ntf.size() ? exp_ntf.pop_front() : 'x;
      `CHK({ntf_thread, ntf_secondary}, e[12:0])
    end
  end

  task automatic push(logic [31:0] d, logic [255:0] p, logic [11:0] s);
    @(negedge clk);
    req_valid = 1'b1;
    req_desc = d;
    req_payload = p;
    req_sender = s;
    req_post_reg = 8'($urandom);
    while (!req_ready) @(negedge clk);
    @(posedge clk);
  endtask : push
  task automatic idle();
    @(negedge clk);
    req_valid = 1'b0;
  endtask : idle
  task automatic ack(logic [11:0] s, logic [2:0] err);
    exp_wb.push_back({s, req_post_reg, 224'h0, 12'h0, TMG_SFID, 13'h0, err, TMG_BE_ACK});
  endtask : ack
  task automatic drain();
    for (int i = 0; i < 3000 && (exp_wb.size() || exp_ntf.size()); i++) @(negedge clk);
    repeat (8) @(negedge clk);
    `CHK(exp_wb.size() + exp_ntf.size(), 0)
  endtask : drain
  task automatic final_report();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report

  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    final_report();
  end

  initial begin
    logic [11:0] t, s;
    logic [7:0] base, roff;
    logic [4:0] o;
    logic [255:0] p;
    logic [31:0] m;
    logic [63:0] rv;
    void'($urandom(42067));
    t = 12'($urandom);
    s = t ^ 12'h801;
    wall_time = {$urandom, $urandom};
    repeat (2) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    ctx_restore_time = {$urandom, $urandom};
    ctx_restore = 1'b1;
    for (int i = 0; i < 5000 && !init_done; i++) begin
      @(negedge clk);
      ctx_restore = 1'b0;
      ctx_run = 1'($urandom);
    end
    `CHK(init_done, 1'b1)
    rv = {$urandom, $urandom};
    ctx_restore_time = rv;
    ctx_restore = 1'b1;
    ctx_run = 1'b0;
    base = 8'(1 + $urandom % 60);
    @(negedge clk);
    ctx_restore = 1'b0;
    push(dsc(TMG_OP_OPEN, 1'b1, 2'h0), 256'(base) << (TMG_DW5 + 21), t);
    ack(t, TMG_ERR_OK);
    for (int len = 0; len < 5; len++) begin
      o = 5'($urandom) & ~5'((1 << len) - 1);
      m = (32'h1 << (1 << len)) - 32'h1;
      roff = 8'($urandom % 64);
      for (int k = 0; k < 8; k++) p[32*k+:32] = $urandom;
      if (len == 0) p[31:8] = {3{p[7:0]}};
      p[191:160] = {3'h0, roff, o, 5'h0, 3'(len), 8'($urandom)};
      p[159:128] = rcp(t);
      push(dsc(TMG_OP_FWD, len != 3, 2'(len % 3)), p, s);
      exp_wb.push_back({t, 8'(base + roff), {128'h0, p[127:0]} << (8 * o), m << o});
      if (len % 3 != 0) exp_ntf.push_back({t, len % 3 == 2});
      if (len != 3) ack(s, TMG_ERR_OK);
    end
    for (int k = 0; k < 7; k++) begin
      p[191:160] = {21'h0, 3'(k < 3 ? 5 + k : 2), 8'h0};
      push(dsc(OPS[k], 1'b1, 2'h0), p, k == 5 ? t : s);
      ack(k == 5 ? t : s, ERRS[k]);
    end
    for (int h = 0; h < 2; h++) begin
      push(dsc(TMG_OP_TIME, 1'b1, 2'h0), 256'(h) << (TMG_DW5 + TMG_F_HALF), s);
      exp_wb.push_back({s, req_post_reg, 256'({rv[43:12], rv[11:0], 20'h0, wall_time[43:12],
        wall_time[11:0], 20'h0}) << (128 * h), h ? TMG_BE_HIGH : TMG_BE_LOW});
    end
    // State update is consumed silently; a stray writeback would pop an empty queue
    push(dsc(TMG_OP_BUPD, 1'b1, 2'h0), '0, s);
    idle();
    bar_cfg_id = 4'h5;
    bar_cfg_count = 6'h3;
    bar_cfg_valid = 1'b1;
    @(negedge clk);
    bar_cfg_valid = 1'b0;
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 3 - r; i++) begin
        push(dsc(TMG_OP_BAR, 1'b1, 2'h0), 256'({8'h5, 8'h0, 1'(r), 6'(3 - r), 9'h0}) << TMG_DW2,
          12'(s + i));
        exp_ntf.push_back({12'(s + i), 1'b0});
      end
    end
    idle();
    drain();
    stall = 1'b1;
    for (int i = 0; i < 33; i++) begin
      push(dsc(TMG_OP_CLOSE, 1'b1, 2'h0), '0, s);
      ack(s, TMG_ERR_OK);
    end
    idle();
    @(negedge clk);
    `CHK(req_ready, 1'b0)
    stall = 1'b0;
    drain();
    `CHK(req_ready, 1'b1)
    final_report();
  end
endmodule : tb_tmg_gateway
